// file: src/ccw_top.sv
// Register window front end of the calendar clock unit
// ==========================================================
// Notes on behaviour
// - Time pointer in clock config bits 9:8 selects the time window pair.
// - Time pointer 00 min/sec, 01 weekday/hours, 10 month/day, 11 year.
// - High-byte time writes step the pointer down, holding at 00.
// - Alarm pointer in alarm config bits 9:8 selects the alarm pair.
// - Alarm pointer 00 min/sec, 01 weekday/hours, 10 month/day, 11 none.
// - High-byte alarm writes step the alarm pointer down, holding at 00.
// - Any read of either alarm window byte steps the alarm pointer down.
// - Any read of either time window byte steps the time pointer down.
// - Low-byte writes leave the window pointer unchanged.
// - Time values accept writes only while the write enable bit is set.
// - Write enable sets only right after keys 55h then AAh.
// - Year reads zero above bit 7; tens in 7-4, ones in 3-0.
// - Month byte: 15-13 zero, tens at bit 12, ones at 11-8.
// - Day byte: 7-6 zero, tens at 5-4, ones at 3-0.
// - Year and month/day writes need write enable equal to one.
// ==========================================================
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
module ccw_top
	import ccw_pkg::*;
#(
	parameter int ADDR_W = CCW_ADDR_W
) (
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	input  wire logic [ADDR_W-1:0]  addr_i,
	input  wire logic [15:0]        wdata_i,
	input  wire logic               wr_i,
	input  wire logic               rd_i,
	output logic      [15:0]        rdata_o,
	output logic                    time_write_enable_o,
	output logic      [1:0]         time_ptr_o,
	output logic      [1:0]         alarm_ptr_o,
	output logic                    unlock_open_o
);

	// ==========================================================
	// Elaboration check
	// Refuse settings that the decode and store below cannot serve
	if (ADDR_W < CCW_ADDR_W) begin : g_bad_addr
		$error("ccw_top: ADDR_W too narrow for the register map");
	end

	if (CCW_PTR_MSB != CCW_PTR_LSB + 1) begin : g_bad_ptr
		$error("ccw_top: pointer field must be two bits wide");
	end

	if (CCW_WREN_BIT >= CCW_DATA_W) begin : g_bad_wren
		$error("ccw_top: write enable bit outside the data word");
	end

	if (CCW_STORE_AW != 4) begin : g_bad_store
		$error("ccw_top: store address is alarm, pointer, high byte");
	end

	// ==========================================================
	// Reset release
	logic rst_meta_r;
	logic rst_sync_r;
	logic rst_n;

	// Two stages so release never lands mid-edge on the logic
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// Only this pair sees the raw pin; every other flop uses rst_n
	assign rst_n = rst_sync_r;

	// ==========================================================
	// Address decode
	logic hit_clk_cfg;
	logic hit_time_hi;
	logic hit_time_lo;
	logic hit_alm_cfg;
	logic hit_alm_hi;
	logic hit_alm_lo;
	logic hit_key;
	logic hit_window;

	// Index 7 decodes to nothing and reads as zero
	assign hit_clk_cfg = addr_i == ADDR_W'(CCW_OFF_CLK_CFG);
	assign hit_time_hi = addr_i == ADDR_W'(CCW_OFF_TIME_HI);
	assign hit_time_lo = addr_i == ADDR_W'(CCW_OFF_TIME_LO);
	assign hit_alm_cfg = addr_i == ADDR_W'(CCW_OFF_ALM_CFG);
	assign hit_alm_hi  = addr_i == ADDR_W'(CCW_OFF_ALM_HI);
	assign hit_alm_lo  = addr_i == ADDR_W'(CCW_OFF_ALM_LO);
	assign hit_key     = addr_i == ADDR_W'(CCW_OFF_KEY);
	assign hit_window  = hit_time_hi | hit_time_lo | hit_alm_hi | hit_alm_lo;

	// ==========================================================
	// Access events
	logic wr_clk_cfg;
	logic wr_alm_cfg;
	logic wr_key;
	logic wr_time_hi;
	logic wr_time_lo;
	logic wr_alm_hi;
	logic wr_alm_lo;
	logic rd_time;
	logic rd_alm;

	// One-cycle strobes, so each event fires once per access
	assign wr_clk_cfg = wr_i & hit_clk_cfg;
	assign wr_alm_cfg = wr_i & hit_alm_cfg;
	assign wr_key     = wr_i & hit_key;
	assign wr_time_hi = wr_i & hit_time_hi;
	assign wr_time_lo = wr_i & hit_time_lo;
	assign wr_alm_hi  = wr_i & hit_alm_hi;
	assign wr_alm_lo  = wr_i & hit_alm_lo;
	assign rd_time    = rd_i & (hit_time_hi | hit_time_lo);
	assign rd_alm     = rd_i & (hit_alm_hi | hit_alm_lo);

	// ==========================================================
	// State registers
	// Next values come from the combinational blocks below
	logic [1:0] time_ptr_r;
	logic [1:0] time_ptr_nxt;
	logic [1:0] alm_ptr_r;
	logic [1:0] alm_ptr_nxt;
	logic       wren_r;
	logic       wren_nxt;
	ccw_key_t   key_r;
	ccw_key_t   key_nxt;

	// ==========================================================
	// Link to the value store, declared ahead of its drivers
	ccw_store_if st ();

	// ==========================================================
	// Time pointer stepping
	logic time_step;
	logic time_at_floor;

	// Reads of either byte step too: the core cannot tell widths
	assign time_step     = wr_time_hi | rd_time;
	assign time_at_floor = time_ptr_r == CCW_PTR_MIN_SEC;

	// A locked high-byte write still steps, so fill loops stay in step
	// At 00 the pointer holds until software loads a new value
	// Software load wins; otherwise step down and stick at zero
	always_comb begin
		time_ptr_nxt = time_ptr_r;
		if (wr_clk_cfg) begin
			time_ptr_nxt = wdata_i[CCW_PTR_MSB:CCW_PTR_LSB];
		end else if (time_step && !time_at_floor) begin
			time_ptr_nxt = time_ptr_r - 2'h1;
		end
	end

	// ==========================================================
	// Alarm pointer stepping
	logic alm_step;
	logic alm_at_floor;

	assign alm_step     = wr_alm_hi | rd_alm;
	assign alm_at_floor = alm_ptr_r == CCW_PTR_MIN_SEC;

	// Same policy as the time pointer; code 11 selects nothing
	// but still steps down to 10 on the next high-byte write or window read
	always_comb begin
		alm_ptr_nxt = alm_ptr_r;
		if (wr_alm_cfg) begin
			alm_ptr_nxt = wdata_i[CCW_PTR_MSB:CCW_PTR_LSB];
		end else if (alm_step && !alm_at_floor) begin
			alm_ptr_nxt = alm_ptr_r - 2'h1;
		end
	end

	// ==========================================================
	// Unlock sequencer
	logic key_is_first;
	logic key_is_second;
	logic any_access;

	// Only the low byte of a key write is compared
	assign key_is_first  = wdata_i[7:0] == CCW_KEY_FIRST;
	assign key_is_second = wdata_i[7:0] == CCW_KEY_SECOND;
	assign any_access    = wr_i | rd_i;

	// Window is exactly one access wide; anything else closes it.
	// A 55 write in any state restarts the pair, so a retry after
	// an interrupted sequence still opens the window.
	always_comb begin
		key_nxt = key_r;
		case (key_r)
			CCW_KEY_IDLE: begin
				if (wr_key && key_is_first) begin
					key_nxt = CCW_KEY_HALF;
				end
			end
			CCW_KEY_HALF: begin
				if (wr_key && key_is_second) begin
					key_nxt = CCW_KEY_OPEN;
				end else if (wr_key && key_is_first) begin
					key_nxt = CCW_KEY_HALF;
				end else if (any_access) begin
					key_nxt = CCW_KEY_IDLE;
				end
			end
			CCW_KEY_OPEN: begin
				if (wr_key && key_is_first) begin
					key_nxt = CCW_KEY_HALF;
				end else if (any_access) begin
					key_nxt = CCW_KEY_IDLE;
				end
			end
			default: begin
				key_nxt = CCW_KEY_IDLE;
			end
		endcase
	end

	// ==========================================================
	// Write enable bit
	logic key_open;

	assign key_open = key_r == CCW_KEY_OPEN;

	// Clearing is always allowed; setting needs the open window,
	// or the bit already set, so a rewrite of 1 keeps it
	always_comb begin
		wren_nxt = wren_r;
		if (wr_clk_cfg) begin
			wren_nxt = wdata_i[CCW_WREN_BIT] & (wren_r | key_open);
		end
	end

	// ==========================================================
	// Control state flops
	// Pointers, enable and sequencer share one reset and one edge
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			time_ptr_r <= CCW_PTR_RST;
			alm_ptr_r  <= CCW_PTR_RST;
			wren_r     <= CCW_WREN_RST;
			key_r      <= CCW_KEY_IDLE;
		end else begin
			time_ptr_r <= time_ptr_nxt;
			alm_ptr_r  <= alm_ptr_nxt;
			wren_r     <= wren_nxt;
			key_r      <= key_nxt;
		end
	end

	// ==========================================================
	// Store write path
	logic       time_wr_ok;
	logic       alm_wr_ok;
	logic       st_hi;
	logic       st_alarm;
	logic [1:0] st_ptr;
	logic [7:0] st_mask;
	logic       sel_month;
	logic       sel_day;
	logic       sel_year_hi;
	logic [7:0] wr_byte;

	// Year high byte has no cell; alarm code 11 has no register.
	// Alarm writes skip the lock: only time values are guarded.
	assign time_wr_ok = wren_r
		& (wr_time_lo | (wr_time_hi & (time_ptr_r != CCW_PTR_YEAR)));
	assign alm_wr_ok  = (wr_alm_hi | wr_alm_lo)
		& (alm_ptr_r != CCW_PTR_YEAR);
	assign st_alarm   = hit_alm_hi | hit_alm_lo;
	assign st_hi      = hit_time_hi | hit_alm_hi;
	assign st_ptr     = st_alarm ? alm_ptr_r : time_ptr_r;

	// Unimplemented date bits are dropped on the way in
	assign sel_month   = (st_ptr == CCW_PTR_MTH_DAY) &  st_hi;
	assign sel_day     = (st_ptr == CCW_PTR_MTH_DAY) & ~st_hi;
	assign sel_year_hi = (st_ptr == CCW_PTR_YEAR)    &  st_hi;
	assign st_mask     = sel_month   ? CCW_MASK_MONTH :
		sel_day     ? CCW_MASK_DAY  :
		sel_year_hi ? CCW_MASK_NONE : CCW_MASK_FULL;

	// High-byte writes carry their byte in bits 15:8, as in the
	// 16-bit window; reads hand back every byte in bits 7:0
	assign wr_byte    = st_hi ? wdata_i[15:8] : wdata_i[7:0];

	// Locked writes never reach the store
	assign st.wr_en   = time_wr_ok | alm_wr_ok;
	assign st.wr_addr = {st_alarm, st_ptr, st_hi};
	assign st.wr_data = wr_byte & st_mask;

	// ==========================================================
	// Read path
	logic [15:0] clk_cfg_view;
	logic [15:0] alm_cfg_view;

	assign clk_cfg_view = (16'(wren_r) << CCW_WREN_BIT)
		| (16'(time_ptr_r) << CCW_PTR_LSB);
	assign alm_cfg_view = 16'(alm_ptr_r) << CCW_PTR_LSB;

	// Window reads pick the current pair before the pointer steps;
	// the key register and holes read zero
	assign st.rd_en    = rd_i;
	assign st.rd_addr  = {st_alarm, st_ptr, st_hi};
	assign st.byp_en   = ~hit_window;
	assign st.byp_data = hit_clk_cfg ? clk_cfg_view :
		hit_alm_cfg ? alm_cfg_view : 16'h0000;

	// ==========================================================
	// Store and its registered read data
	ccw_value_store #(
		.DEPTH (CCW_STORE_DEPTH)
	) ccw_value_store_i (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.st      (st)
	);

	// Window byte sits in bits 7:0 of the read word and
	// leaves the store's output flop with no logic after it
	assign rdata_o = st.rd_data;

	// ==========================================================
	// Status outputs, one flop each
	// Fed from next values so each matches its state flop in step
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			time_write_enable_o <= CCW_WREN_RST;
			time_ptr_o          <= CCW_PTR_RST;
			alarm_ptr_o         <= CCW_PTR_RST;
			unlock_open_o       <= 1'b0;
		end else begin
			time_write_enable_o <= wren_nxt;
			time_ptr_o          <= time_ptr_nxt;
			alarm_ptr_o         <= alm_ptr_nxt;
			unlock_open_o       <= key_nxt == CCW_KEY_OPEN;
		end
	end

endmodule

// file: shared/ccw_pkg.sv
// Constants and types shared by the calendar clock register window
package ccw_pkg;

	// ==========================================================
	// Bus geometry
	localparam int          CCW_ADDR_W      = 3;
	localparam int          CCW_DATA_W      = 16;
	localparam int          CCW_BYTE_W      = 8;

	// ==========================================================
	// Register offsets (word index on the plain port)
	localparam logic [2:0]  CCW_OFF_CLK_CFG = 3'h0;
	localparam logic [2:0]  CCW_OFF_TIME_HI = 3'h1;
	localparam logic [2:0]  CCW_OFF_TIME_LO = 3'h2;
	localparam logic [2:0]  CCW_OFF_ALM_CFG = 3'h3;
	localparam logic [2:0]  CCW_OFF_ALM_HI  = 3'h4;
	localparam logic [2:0]  CCW_OFF_ALM_LO  = 3'h5;
	localparam logic [2:0]  CCW_OFF_KEY     = 3'h6;

	// ==========================================================
	// Field positions
	localparam int          CCW_WREN_BIT    = 13;
	localparam int          CCW_PTR_LSB     = 8;
	localparam int          CCW_PTR_MSB     = 9;

	// ==========================================================
	// Reset values
	localparam logic [1:0]  CCW_PTR_RST     = 2'h0;
	localparam logic        CCW_WREN_RST    = 1'b0;
	localparam logic [7:0]  CCW_BYTE_RST    = 8'h00;

	// ==========================================================
	// Pointer codes
	localparam logic [1:0]  CCW_PTR_MIN_SEC = 2'h0;
	localparam logic [1:0]  CCW_PTR_WD_HR   = 2'h1;
	localparam logic [1:0]  CCW_PTR_MTH_DAY = 2'h2;
	localparam logic [1:0]  CCW_PTR_YEAR    = 2'h3;

	// ==========================================================
	// Unlock key sequence
	localparam logic [7:0]  CCW_KEY_FIRST   = 8'h55;
	localparam logic [7:0]  CCW_KEY_SECOND  = 8'hAA;

	// ==========================================================
	// Implemented bits of the date bytes, the rest read zero
	localparam logic [7:0]  CCW_MASK_FULL   = 8'hFF;
	localparam logic [7:0]  CCW_MASK_MONTH  = 8'h1F;
	localparam logic [7:0]  CCW_MASK_DAY    = 8'h3F;
	localparam logic [7:0]  CCW_MASK_NONE   = 8'h00;

	// ==========================================================
	// Value store: {alarm, pointer, high byte} addresses 16 bytes
	localparam int          CCW_STORE_AW    = 4;
	localparam int          CCW_STORE_DEPTH = 16;

	// Unlock sequencer states
	typedef enum logic [1:0] {
		CCW_KEY_IDLE = 2'b00,
		CCW_KEY_HALF = 2'b01,
		CCW_KEY_OPEN = 2'b10
	} ccw_key_t;

endpackage

// file: shared/ccw_store_if.sv
// Write and read signals between the window logic and the value store
`timescale 1ns/100ps
interface ccw_store_if;
	import ccw_pkg::*;

	logic                      wr_en;
	logic [CCW_STORE_AW-1:0]   wr_addr;
	logic [CCW_BYTE_W-1:0]     wr_data;
	logic                      rd_en;
	logic [CCW_STORE_AW-1:0]   rd_addr;
	logic                      byp_en;
	logic [CCW_DATA_W-1:0]     byp_data;
	logic [CCW_DATA_W-1:0]     rd_data;

	// Window logic side
	modport ctl (
		output wr_en, wr_addr, wr_data, rd_en, rd_addr, byp_en, byp_data,
		input  rd_data
	);

	// Value store side
	modport mem (
		input  wr_en, wr_addr, wr_data, rd_en, rd_addr, byp_en, byp_data,
		output rd_data
	);

endinterface

// file: src/ccw_value_store.sv
// Byte store for time and alarm values with a registered read port
`timescale 1ns/100ps
module ccw_value_store
	import ccw_pkg::*;
#(
	parameter int DEPTH = CCW_STORE_DEPTH
) (
	input  wire logic  clk_i,
	input  wire logic  rst_n_i,
	ccw_store_if.mem   st
);

	// ==========================================================
	// Elaboration check
	if (DEPTH != (1 << CCW_STORE_AW)) begin : g_bad_depth
		$error("ccw_value_store: DEPTH must match the store address");
	end

	logic [CCW_BYTE_W-1:0] cell_r [DEPTH];
	logic [CCW_DATA_W-1:0] rd_data_r;

	// ==========================================================
	// Cells clear at reset so unwritten places read zero
	for (genvar i = 0; i < DEPTH; i++) begin : g_cell
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				cell_r[i] <= CCW_BYTE_RST;
			end else if (st.wr_en && st.wr_addr == CCW_STORE_AW'(i)) begin
				cell_r[i] <= st.wr_data;
			end
		end
	end

	// Read data stand for one cycle only, zero otherwise
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_r <= '0;
		end else if (st.rd_en && st.byp_en) begin
			rd_data_r <= st.byp_data;
		end else if (st.rd_en) begin
			rd_data_r <= {8'h00, cell_r[st.rd_addr]};
		end else begin
			rd_data_r <= '0;
		end
	end

	assign st.rd_data = rd_data_r;

endmodule

// file: verif/ccw_top_asserts.sv
// Port-level checks for the calendar clock register window
`timescale 1ns/100ps
module ccw_top_asserts
	import ccw_pkg::*;
#(
	parameter int ADDR_W = CCW_ADDR_W
) (
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [15:0]       wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	input  wire logic [15:0]       rdata_o,
	input  wire logic              time_write_enable_o,
	input  wire logic [1:0]        time_ptr_o,
	input  wire logic [1:0]        alarm_ptr_o,
	input  wire logic              unlock_open_o
);
	// ==========================================================
	// Decoded strobes
	wire       w_cfg = wr_i && addr_i == CCW_OFF_CLK_CFG;
	wire       w_acf = wr_i && addr_i == CCW_OFF_ALM_CFG;
	wire       w_thi = wr_i && addr_i == CCW_OFF_TIME_HI;
	wire       w_tlo = wr_i && addr_i == CCW_OFF_TIME_LO;
	wire       w_ahi = wr_i && addr_i == CCW_OFF_ALM_HI;
	wire       r_thi = rd_i && addr_i == CCW_OFF_TIME_HI;
	wire       r_t   = r_thi || (rd_i && addr_i == CCW_OFF_TIME_LO);
	wire       r_a   = rd_i && addr_i inside {CCW_OFF_ALM_HI, CCW_OFF_ALM_LO};
	wire [1:0] w_ptr = wdata_i[9:8];

	// Step down, but never below zero
	function automatic logic [1:0] dn(input logic [1:0] p);
		return (p == 2'h0) ? 2'h0 : p - 2'h1;
	endfunction

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// ==========================================================
	// Pointers
	AST_TPTR_LOAD: assert property (
		w_cfg |=> time_ptr_o == $past(w_ptr)) else $error("tptr load");
	AST_APTR_LOAD: assert property (
		w_acf |=> alarm_ptr_o == $past(w_ptr)) else $error("aptr load");
	AST_TPTR_STEP: assert property (
		w_thi |=> time_ptr_o == dn($past(time_ptr_o))) else $error("tptr wr");
	AST_TPTR_RD: assert property (
		r_t |=> time_ptr_o == dn($past(time_ptr_o))) else $error("tptr rd");
	AST_TPTR_LOHOLD: assert property (
		w_tlo |=> $stable(time_ptr_o)) else $error("tptr lo write");
	AST_APTR_STEP: assert property (
		w_ahi |=> alarm_ptr_o == dn($past(alarm_ptr_o))) else $error("aptr wr");
	AST_APTR_RD: assert property (
		r_a |=> alarm_ptr_o == dn($past(alarm_ptr_o))) else $error("aptr rd");

	// ==========================================================
	// Write lock and date layout
	AST_WREN_LOCK: assert property (
		w_cfg && !unlock_open_o && !time_write_enable_o |=>
		!time_write_enable_o) else $error("enable set while locked");
	AST_WREN_OPEN: assert property (
		w_cfg && unlock_open_o && wdata_i[13] |=> time_write_enable_o)
		else $error("enable not set in window");
	AST_YEAR_HI: assert property (
		r_thi && time_ptr_o == CCW_PTR_YEAR |=> rdata_o == 16'h0000)
		else $error("year high byte not zero");
	AST_MONTH: assert property (
		r_thi && time_ptr_o == CCW_PTR_MTH_DAY |=> rdata_o[7:5] == 3'h0)
		else $error("month unused bits set");

	// Main scenarios reached
	cover property (w_cfg && unlock_open_o);
	cover property (r_thi && time_ptr_o == CCW_PTR_YEAR);
	cover property (w_ahi && alarm_ptr_o == CCW_PTR_MIN_SEC);
endmodule

bind ccw_top ccw_top_asserts #(.ADDR_W(ADDR_W)) ccw_top_asserts_i (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.time_write_enable_o(time_write_enable_o), .time_ptr_o(time_ptr_o),
	.alarm_ptr_o(alarm_ptr_o), .unlock_open_o(unlock_open_o)
);

// file: verif/testbench.sv
// Self-checking bench for the calendar clock register window
`timescale 1ns/100ps
module testbench;
	import ccw_pkg::*;

	logic        clk_i     = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [2:0]  addr_i    = 3'h0;
	logic [15:0] wdata_i   = 16'h0000;
	logic        wr_i      = 1'b0;
	logic        rd_i      = 1'b0;
	logic [15:0] rdata_o;
	logic        time_write_enable_o;
	logic [1:0]  time_ptr_o;
	logic [1:0]  alarm_ptr_o;
	logic        unlock_open_o;
	int          n_mismatch = 0;
	int          cmp_count  = 0;

	ccw_top ccw_top_i (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.time_write_enable_o(time_write_enable_o), .time_ptr_o(time_ptr_o),
		.alarm_ptr_o(alarm_ptr_o), .unlock_open_o(unlock_open_o)
	);

	// ==========================================================
	// Clock, 20 ns period
	initial begin
		forever #10 clk_i = ~clk_i;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Pointers packed as {time, alarm}, compared after every access;
	// high-byte writes carry their byte in bits 15:8 of the data
	task automatic wr(input logic [2:0] a, input logic [15:0] d,
		input logic [3:0] p);
		wr_i <= 1'b1;
		rd_i <= 1'b0;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		#1;
		chk({12'h000, time_ptr_o, alarm_ptr_o}, {12'h000, p});
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [15:0] e,
		input logic [3:0] p);
		rd_i <= 1'b1;
		wr_i <= 1'b0;
		addr_i <= a;
		@(posedge clk_i);
		#1;
		chk(rdata_o, e);
		chk({12'h000, time_ptr_o, alarm_ptr_o}, {12'h000, p});
	endtask

	// Enable and unlock flags as {enable, open}
	task automatic st(input logic [1:0] e);
		chk({14'h0000, time_write_enable_o, unlock_open_o}, {14'h0000, e});
	endtask

	task automatic idle(input string name);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk(rdata_o, 16'h0000);
		$display("test %s done", name);
	endtask

	task automatic results;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Watchdog: the tests need well under 200 cycles
	initial begin
		repeat (2000) @(posedge clk_i);
		n_mismatch++;
		results();
	end

	// ==========================================================
	// Tests
	initial begin
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		st(2'h0);
		// Locked: enable refused, writes dropped
		wr(3'h0, 16'h2300, 4'hC);
		st(2'h0);
		wr(3'h2, 16'h0012, 4'hC);
		rd(3'h2, 16'h0000, 4'h8);
		idle("lock");
		// Unlock, then fill every time pair
		wr(3'h6, 16'h0055, 4'h8);
		wr(3'h6, 16'h00AA, 4'h8);
		st(2'h1);
		wr(3'h0, 16'h2300, 4'hC);
		st(2'h2);
		wr(3'h2, 16'h0099, 4'hC);
		wr(3'h1, 16'hFF00, 4'h8);
		wr(3'h2, 16'h00FF, 4'h8);
		wr(3'h1, 16'hFF00, 4'h4);
		wr(3'h2, 16'h0023, 4'h4);
		wr(3'h1, 16'h0600, 4'h0);
		wr(3'h2, 16'h0045, 4'h0);
		wr(3'h1, 16'h5900, 4'h0);
		wr(3'h0, 16'h2300, 4'hC);
		rd(3'h1, 16'h0000, 4'h8);
		rd(3'h2, 16'h003F, 4'h4);
		rd(3'h1, 16'h0006, 4'h0);
		rd(3'h2, 16'h0045, 4'h0);
		rd(3'h1, 16'h0059, 4'h0);
		wr(3'h0, 16'h2300, 4'hC);
		rd(3'h2, 16'h0099, 4'h8);
		rd(3'h1, 16'h001F, 4'h4);
		rd(3'h2, 16'h0023, 4'h0);
		idle("fill");
		// Relock: stored values survive writes
		wr(3'h0, 16'h0000, 4'h0);
		st(2'h0);
		wr(3'h2, 16'h0011, 4'h0);
		wr(3'h1, 16'h2200, 4'h0);
		rd(3'h2, 16'h0045, 4'h0);
		rd(3'h1, 16'h0059, 4'h0);
		// Key window closed by a hole read before the enable write, hole and key read zero
		wr(3'h6, 16'h0055, 4'h0);
		wr(3'h6, 16'h00AA, 4'h0);
		rd(3'h7, 16'h0000, 4'h0);
		wr(3'h0, 16'h2000, 4'h0);
		st(2'h0);
		rd(3'h6, 16'h0000, 4'h0);
		idle("key");
		// Alarm window, not locked
		wr(3'h3, 16'h0300, 4'h3);
		wr(3'h4, 16'h7700, 4'h2);
		wr(3'h5, 16'h0015, 4'h2);
		wr(3'h4, 16'h1200, 4'h1);
		wr(3'h5, 16'h0008, 4'h1);
		wr(3'h4, 16'h0300, 4'h0);
		wr(3'h5, 16'h0030, 4'h0);
		wr(3'h4, 16'h4500, 4'h0);
		wr(3'h3, 16'h0200, 4'h2);
		rd(3'h5, 16'h0015, 4'h1);
		rd(3'h4, 16'h0003, 4'h0);
		rd(3'h5, 16'h0030, 4'h0);
		rd(3'h4, 16'h0045, 4'h0);
		wr(3'h3, 16'h0300, 4'h3);
		rd(3'h4, 16'h0000, 4'h2);
		rd(3'h4, 16'h0012, 4'h1);
		rd(3'h5, 16'h0008, 4'h0);
		idle("alarm");
		results();
	end
endmodule
